// ---- src/dac_host_pkg.sv ----
// Purpose: Shared constants and types for the DAC serial host interface
// Assumes: 24-bit clocked serial words and a 32-channel device
// Notes:   Pin group travels as one struct so it can be synchronised in one step
package dac_host_pkg;

  localparam int          WORD_BITS    = 24;
  localparam int          TOGGLE_POS   = 23;
  localparam int          RW_POS       = 22;
  localparam int          CHAN_LSB     = 16;
  localparam int          REG_HI_POS   = 15;
  localparam int          REG_LO_POS   = 14;
  localparam int          DATA_BITS    = 14;
  localparam int          ECHO_BITS    = 10;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [4:0]  FULL_COUNT   = 5'h18;
  localparam logic [4:0]  SLAVE_FIXED  = 5'h15;
  localparam logic [7:0]  BURST_PTR    = 8'hFF;
  localparam logic [4:0]  LAST_CHANNEL = 5'h1F;
  localparam logic [2:0]  LAST_BIT     = 3'h7;

  typedef struct packed {
    logic       toggle_ab;
    logic [4:0] channel_address;
    logic       register_select_hi;
    logic       register_select_lo;
    logic [13:0] data_field;
  } dac_word_t;

  typedef struct packed {
    logic [4:0] channel_address;
    logic       register_select_hi;
    logic       register_select_lo;
  } readback_sel_t;

  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic din;
    logic chain;
    logic sp_sel;
    logic st_sel;
    logic scl;
    logic sda;
    logic ad_hi;
    logic ad_lo;
  } pins_t;

  typedef enum logic [1:0] {
    TW_IDLE = 2'b00,
    TW_RX   = 2'b01,
    TW_ACK  = 2'b11,
    TW_SKIP = 2'b10
  } tw_state_t;

  typedef enum logic [1:0] {
    BK_ADDR = 2'b00,
    BK_PTR  = 2'b01,
    BK_DHI  = 2'b11,
    BK_DLO  = 2'b10
  } byte_kind_t;

endpackage

// ---- src/word_fifo.sv ----
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Pointers carry one extra bit to tell full from empty
module word_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb
  begin
    next_wr_ptr = do_wr ? AW'(1) + wr_ptr : wr_ptr;
    next_rd_ptr = do_rd ? AW'(1) + rd_ptr : rd_ptr;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule // word_fifo

// ---- src/dac_serial_host_interface.sv ----
// Purpose: Clocked-frame serial port and write-only two-wire slave of a multichannel DAC
// Assumes: All pins are asynchronous to clk_sys and pass two flip-flops first
// Notes:   Decoded channel words leave through a 32-word FIFO
// What this block does
// - Chain pin high: keep shifting past 24 bits and forward data to serial out.
// - In chain mode, bits beyond 24 clocks ripple out oldest first.
// - Serial out changes on rising serial clock, valid on falling edge.
// - Frame sync rising after full transfer latches the word; no more bits taken.
// - Frame sync rising before 24 clocks discards the frame as bad.
// - Read bit set selects channel and register for readback; data field ignored.
// - Next frame shifts out 10 echoed address bits then 14-bit register value.
// - First readback bit appears at the falling edge of frame sync.
// - Two-wire slave works only when both select pins are high.
// - Slave address is five fixed bits plus the two address pin levels.
// - Slave only, never drives the bus clock, up to 400 kHz.
// - Idle until START followed by own address.
// - Acknowledge each accepted byte by pulling data low in ninth clock.
// - Address, pointer, two data bytes, STOP updates one channel.
// - Without STOP, further pointer plus data pairs update more channels.
// - Pointer 0xFF starts burst at channel 0 with auto increment.
// - Burst register choice comes from the data bytes; no A/B toggle.
// - After channel 31 burst falls back to pointer mode; STOP ends burst.
// - Serial word: toggle, read bit, zero, channel, two register bits, data.
module dac_serial_host_interface (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        sclk_pin,
  input  wire logic                        sync_n_pin,
  input  wire logic                        din_pin,
  input  wire logic                        chain_enable_pin,
  output logic                             serial_out_pin,
  input  wire logic                        serial_parallel_select,
  input  wire logic                        serial_type_select,
  input  wire logic                        scl_pin,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  input  wire logic                        bus_addr_pin_hi,
  input  wire logic                        bus_addr_pin_lo,
  output logic                             word_valid,
  input  wire logic                        word_ready,
  output dac_host_pkg::dac_word_t          word,
  output logic                             readback_req,
  output dac_host_pkg::readback_sel_t      readback_sel,
  input  wire logic [13:0]                 readback_data,
  output logic                             bad_frame,
  output logic                             word_dropped
);
  dac_host_pkg::pins_t      pin_raw;
  dac_host_pkg::pins_t      pin_meta;
  dac_host_pkg::pins_t      pin_s;
  dac_host_pkg::pins_t      pin_prev;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic                     sync_fall;
  logic                     sync_rise;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     bus_start;
  logic                     bus_stop;
  logic                     ser_mode;
  logic                     tw_mode;
  logic [23:0]              sr;
  logic [23:0]              next_sr;
  logic [4:0]               cnt;
  logic [4:0]               next_cnt;
  logic                     frame_open;
  logic                     next_frame_open;
  logic                     next_sdo;
  logic                     rb_pending;
  logic                     next_rb_pending;
  logic [9:0]               rb_echo;
  logic [9:0]               next_rb_echo;
  logic                     next_rb_req;
  dac_host_pkg::readback_sel_t next_rb_sel;
  logic                     next_bad;
  logic                     next_drop;
  logic                     ser_push;
  dac_host_pkg::dac_word_t  ser_word;
  dac_host_pkg::tw_state_t  tw_state;
  dac_host_pkg::tw_state_t  next_tw_state;
  dac_host_pkg::byte_kind_t kind;
  dac_host_pkg::byte_kind_t next_kind;
  logic [2:0]               bitn;
  logic [2:0]               next_bitn;
  logic [7:0]               shreg;
  logic [7:0]               next_shreg;
  logic [7:0]               rx_byte;
  logic                     burst;
  logic                     next_burst;
  logic [4:0]               chan;
  logic [4:0]               next_chan;
  logic [7:0]               dhi;
  logic [7:0]               next_dhi;
  logic                     next_oe;
  logic                     addr_match;
  logic                     tw_push;
  dac_host_pkg::dac_word_t  tw_word;
  logic                     push_valid;
  logic                     next_push_valid;
  dac_host_pkg::dac_word_t  push_word;
  dac_host_pkg::dac_word_t  next_push_word;
  logic                     fifo_in_ready;

  assign pin_raw = '{sclk: sclk_pin, sync_n: sync_n_pin, din: din_pin, chain: chain_enable_pin,
                     sp_sel: serial_parallel_select, st_sel: serial_type_select, scl: scl_pin,
                     sda: sda_in, ad_hi: bus_addr_pin_hi, ad_lo: bus_addr_pin_lo};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= '1;
      pin_s    <= '1;
      pin_prev <= '1;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
      pin_prev <= pin_s;
    end
  end

  assign sclk_rise = pin_s.sclk && !pin_prev.sclk;
  assign sclk_fall = !pin_s.sclk && pin_prev.sclk;
  assign sync_fall = !pin_s.sync_n && pin_prev.sync_n;
  assign sync_rise = pin_s.sync_n && !pin_prev.sync_n;
  assign scl_rise  = pin_s.scl && !pin_prev.scl;
  assign scl_fall  = !pin_s.scl && pin_prev.scl;
  assign bus_start = pin_s.scl && pin_prev.scl && !pin_s.sda && pin_prev.sda;
  assign bus_stop  = pin_s.scl && pin_prev.scl && pin_s.sda && !pin_prev.sda;
  assign ser_mode  = pin_s.sp_sel && !pin_s.st_sel;
  assign tw_mode   = pin_s.sp_sel && pin_s.st_sel;

  // Clocked-frame serial port
  always_comb
  begin
    next_sr         = sr;
    next_cnt        = cnt;
    next_frame_open = frame_open;
    next_sdo        = serial_out_pin;
    next_rb_pending = rb_pending;
    next_rb_echo    = rb_echo;
    next_rb_req     = 1'b0;
    next_rb_sel     = readback_sel;
    next_bad        = 1'b0;
    next_drop       = 1'b0;
    ser_push        = 1'b0;
    ser_word        = '{toggle_ab: sr[dac_host_pkg::TOGGLE_POS],
                        channel_address: sr[dac_host_pkg::CHAN_LSB +: 5],
                        register_select_hi: sr[dac_host_pkg::REG_HI_POS],
                        register_select_lo: sr[dac_host_pkg::REG_LO_POS],
                        data_field: sr[dac_host_pkg::DATA_BITS-1:0]};
    if (!ser_mode)
      next_frame_open = 1'b0;
    else if (sync_fall)
    begin
      next_frame_open = 1'b1;
      next_cnt        = '0;
      if (rb_pending)
      begin
        next_sr         = {rb_echo, readback_data};
        next_sdo        = rb_echo[dac_host_pkg::ECHO_BITS-1];
        next_rb_pending = 1'b0;
      end
    end
    else if (sync_rise && frame_open)
    begin
      next_frame_open = 1'b0;
      if (cnt < dac_host_pkg::FULL_COUNT)
        next_bad = 1'b1;
      else if (sr[dac_host_pkg::RW_POS])
      begin
        next_rb_req     = 1'b1;
        next_rb_pending = 1'b1;
        next_rb_echo    = sr[dac_host_pkg::WORD_BITS-1 -: dac_host_pkg::ECHO_BITS];
        next_rb_sel     = '{channel_address: ser_word.channel_address,
                            register_select_hi: ser_word.register_select_hi,
                            register_select_lo: ser_word.register_select_lo};
      end
      else if (push_valid)
        next_drop = 1'b1;
      else
        ser_push = 1'b1;
    end
    else if (frame_open && !pin_s.sync_n)
    begin
      if (sclk_fall && (pin_s.chain || cnt < dac_host_pkg::FULL_COUNT))
      begin
        next_sr = {sr[dac_host_pkg::WORD_BITS-2:0], pin_s.din};
        if (cnt < dac_host_pkg::FULL_COUNT)
          next_cnt = cnt + 5'h1;
      end
      if (sclk_rise)
        next_sdo = sr[dac_host_pkg::WORD_BITS-1];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sr             <= '0;
      cnt            <= '0;
      frame_open     <= 1'b0;
      serial_out_pin <= 1'b0;
      rb_pending     <= 1'b0;
      rb_echo        <= '0;
      readback_req   <= 1'b0;
      readback_sel   <= '0;
      bad_frame      <= 1'b0;
      word_dropped   <= 1'b0;
    end
    else
    begin
      sr             <= next_sr;
      cnt            <= next_cnt;
      frame_open     <= next_frame_open;
      serial_out_pin <= next_sdo;
      rb_pending     <= next_rb_pending;
      rb_echo        <= next_rb_echo;
      readback_req   <= next_rb_req;
      readback_sel   <= next_rb_sel;
      bad_frame      <= next_bad;
      word_dropped   <= next_drop;
    end
  end

  // Two-wire write-only slave; the bus clock is only ever sampled
  assign rx_byte    = {shreg[6:0], pin_s.sda};
  assign addr_match = (rx_byte[7:3] == dac_host_pkg::SLAVE_FIXED) &&
                      (rx_byte[2:1] == {pin_s.ad_hi, pin_s.ad_lo}) && !rx_byte[0];
  assign sda_out    = 1'b0;

  always_comb
  begin
    next_tw_state = tw_state;
    next_kind     = kind;
    next_bitn     = bitn;
    next_shreg    = shreg;
    next_burst    = burst;
    next_chan     = chan;
    next_dhi      = dhi;
    next_oe       = sda_oe;
    tw_push       = 1'b0;
    tw_word       = '{toggle_ab: 1'b0, channel_address: chan, register_select_hi: dhi[7],
                      register_select_lo: dhi[6], data_field: {dhi[5:0], rx_byte}};
    if (!tw_mode || bus_stop)
    begin
      next_tw_state = dac_host_pkg::TW_IDLE;
      next_burst    = 1'b0;
      next_oe       = 1'b0;
    end
    else if (bus_start)
    begin
      next_tw_state = dac_host_pkg::TW_RX;
      next_kind     = dac_host_pkg::BK_ADDR;
      next_bitn     = '0;
      next_burst    = 1'b0;
      next_oe       = 1'b0;
    end
    else
    begin
      case (tw_state)
        dac_host_pkg::TW_RX:
        begin
          if (scl_rise)
          begin
            next_shreg = rx_byte;
            next_bitn  = bitn + 3'h1;
            if (bitn == dac_host_pkg::LAST_BIT)
            begin
              next_tw_state = dac_host_pkg::TW_ACK;
              case (kind)
                dac_host_pkg::BK_ADDR:
                begin
                  if (addr_match)
                    next_kind = dac_host_pkg::BK_PTR;
                  else
                    next_tw_state = dac_host_pkg::TW_SKIP;
                end
                dac_host_pkg::BK_PTR:
                begin
                  next_kind  = dac_host_pkg::BK_DHI;
                  next_burst = (rx_byte == dac_host_pkg::BURST_PTR);
                  next_chan  = next_burst ? '0 : rx_byte[4:0];
                end
                dac_host_pkg::BK_DHI:
                begin
                  next_kind = dac_host_pkg::BK_DLO;
                  next_dhi  = rx_byte;
                end
                default:
                begin
                  if (push_valid)
                    next_tw_state = dac_host_pkg::TW_SKIP;
                  else
                  begin
                    tw_push = 1'b1;
                    if (burst && chan != dac_host_pkg::LAST_CHANNEL)
                    begin
                      next_chan = chan + 5'h1;
                      next_kind = dac_host_pkg::BK_DHI;
                    end
                    else
                    begin
                      next_burst = 1'b0;
                      next_kind  = dac_host_pkg::BK_PTR;
                    end
                  end
                end
              endcase
            end
          end
        end
        dac_host_pkg::TW_ACK:
        begin
          if (scl_fall && !sda_oe)
            next_oe = 1'b1;
          else if (scl_fall)
          begin
            next_oe       = 1'b0;
            next_tw_state = dac_host_pkg::TW_RX;
            next_bitn     = '0;
          end
        end
        default:
          next_oe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tw_state <= dac_host_pkg::TW_IDLE;
      kind     <= dac_host_pkg::BK_ADDR;
      bitn     <= '0;
      shreg    <= '0;
      burst    <= 1'b0;
      chan     <= '0;
      dhi      <= '0;
      sda_oe   <= 1'b0;
    end
    else
    begin
      tw_state <= next_tw_state;
      kind     <= next_kind;
      bitn     <= next_bitn;
      shreg    <= next_shreg;
      burst    <= next_burst;
      chan     <= next_chan;
      dhi      <= next_dhi;
      sda_oe   <= next_oe;
    end
  end

  // One-word holding stage in front of the FIFO; new words are dropped while it is full
  always_comb
  begin
    next_push_valid = push_valid && !fifo_in_ready;
    next_push_word  = push_word;
    if (ser_push || tw_push)
    begin
      next_push_valid = 1'b1;
      next_push_word  = ser_push ? ser_word : tw_word;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      push_valid <= 1'b0;
      push_word  <= '0;
    end
    else
    begin
      push_valid <= next_push_valid;
      push_word  <= next_push_word;
    end
  end

  word_fifo #(.WIDTH($bits(dac_host_pkg::dac_word_t)), .DEPTH(dac_host_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .in_valid (push_valid),
    .in_ready (fifo_in_ready),
    .in_data  (push_word),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data (word)
  );

  sequence s_short_close;
    ser_mode && frame_open && sync_rise && (cnt < dac_host_pkg::FULL_COUNT);
  endsequence
  sequence s_ack_window;
    !sda_oe ##1 sda_oe;
  endsequence

  property p_bad_frame;
    @(posedge clk_sys) disable iff (rst) s_short_close |=> bad_frame && !push_valid ##1 !bad_frame;
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("short frame not flagged");

  property p_standalone_hold;
    @(posedge clk_sys) disable iff (rst)
      ser_mode && frame_open && !pin_s.chain && cnt == dac_host_pkg::FULL_COUNT && !sync_fall |=> $stable(sr);
  endproperty
  a_standalone_hold: assert property (p_standalone_hold) else $error("standalone shifted past 24");

  property p_chain_shift;
    @(posedge clk_sys) disable iff (rst)
      ser_mode && frame_open && pin_s.chain && !pin_s.sync_n && sclk_fall && !sync_fall
      |=> sr == {$past(sr[22:0]), $past(pin_s.din)};
  endproperty
  a_chain_shift: assert property (p_chain_shift) else $error("chain shift wrong");

  property p_out_on_rise;
    @(posedge clk_sys) disable iff (rst)
      ser_mode && frame_open && !pin_s.sync_n && sclk_rise && !sync_fall |=> serial_out_pin == $past(sr[23]);
  endproperty
  a_out_on_rise: assert property (p_out_on_rise) else $error("serial out not updated on rise");

  property p_latch;
    @(posedge clk_sys) disable iff (rst)
      ser_mode && frame_open && sync_rise && cnt == dac_host_pkg::FULL_COUNT && !sr[dac_host_pkg::RW_POS]
      && !push_valid |=> push_valid && push_word.data_field == $past(sr[13:0]) && !frame_open;
  endproperty
  a_latch: assert property (p_latch) else $error("complete frame not latched");

  property p_readback_req;
    @(posedge clk_sys) disable iff (rst)
      ser_mode && frame_open && sync_rise && cnt == dac_host_pkg::FULL_COUNT && sr[dac_host_pkg::RW_POS]
      |=> readback_req && rb_pending && !push_valid ##1 !readback_req;
  endproperty
  a_readback_req: assert property (p_readback_req) else $error("read request mishandled");

  property p_first_rb_bit;
    @(posedge clk_sys) disable iff (rst)
      ser_mode && sync_fall && rb_pending |=> serial_out_pin == $past(rb_echo[9]) && sr[13:0] == $past(readback_data);
  endproperty
  a_first_rb_bit: assert property (p_first_rb_bit) else $error("readback not presented at frame start");

  property p_ack_drive;
    @(posedge clk_sys) disable iff (rst)
      tw_mode && tw_state == dac_host_pkg::TW_ACK && scl_fall && !sda_oe && !bus_stop && !bus_start |-> s_ack_window;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("no acknowledge driven");

  property p_foreign_addr;
    @(posedge clk_sys) disable iff (rst)
      tw_mode && tw_state == dac_host_pkg::TW_RX && kind == dac_host_pkg::BK_ADDR && scl_rise
      && bitn == dac_host_pkg::LAST_BIT && !addr_match && !bus_stop && !bus_start
      |=> tw_state == dac_host_pkg::TW_SKIP && !sda_oe;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address accepted");

  property p_burst_start;
    @(posedge clk_sys) disable iff (rst)
      tw_mode && tw_state == dac_host_pkg::TW_RX && kind == dac_host_pkg::BK_PTR && scl_rise
      && bitn == dac_host_pkg::LAST_BIT && rx_byte == dac_host_pkg::BURST_PTR && !bus_stop && !bus_start
      |=> burst && chan == 5'h0;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not start at channel 0");

  property p_stop_exit;
    @(posedge clk_sys) disable iff (rst) bus_stop || !tw_mode |=> !burst && !sda_oe && tw_state == dac_host_pkg::TW_IDLE;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop or mode change did not end transfer");
endmodule // dac_serial_host_interface

// ---- tb/dac_host_model.sv ----
// Purpose: Host model for the clocked-frame port and the two-wire bus
// Assumes: Serial clock idles high; 8 clk_sys cycles per serial bit
// Notes:   Data in shows the inverse of its last value between frames
module dac_host_model (
  input  wire logic clk_sys,
  input  wire logic so,
  input  wire logic sda,
  output logic      sclk = 1'b1,
  output logic      sync_n = 1'b1,
  output logic      din = 1'b0,
  output logic      scl = 1'b1,
  output logic      sda_m = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic w4;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic frame(input logic [47:0] w, input int n, output logic [47:0] cap);
    cap = '0;
    sync_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din <= w[i];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      cap[i] = so;
      @(posedge clk_sys);
      sclk <= 1'b0;
      w4();
      sclk <= 1'b1;
    end
    w4();
    sync_n <= 1'b1;
    din <= ~din;
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    w4();
    scl <= 1'b1;
    w4();
    r = sda;
    scl <= 1'b0;
    w4();
  endtask
  task automatic xfer(input logic [63:0] w, input int n, output logic [7:0] acks);
    logic r;
    acks = '0;
    sda_m <= 1'b0;
    w4();
    scl <= 1'b0;
    w4();
    for (int k = n - 1; k >= 0; k--)
    begin
      for (int i = 7; i >= 0; i--)
        bit_io(w[8 * k + i], r);
      bit_io(1'b1, acks[k]);
    end
    sda_m <= 1'b0;
    w4();
    scl <= 1'b1;
    w4();
    sda_m <= 1'b1;
    w4();
  endtask
endmodule // dac_host_model

// ---- tb/test_dac_serial_host_interface.sv ----
// Purpose: Self-checking bench for the DAC serial host interface
// Assumes: Words are taken as soon as they are offered, except while t_full holds ready low
// Notes:   Flags are counted on the falling clock edge
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_dac_serial_host_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        clk_sys = 1'b0;
  logic                        rst = 1'b1;
  logic                        chain = 1'b0;
  logic                        stype = 1'b0;
  logic [13:0]                 rb_data = 14'h0000;
  logic                        rdy = 1'b1;
  logic                        sclk, sync_n, din, scl, sda_m, so, sda_oe, word_valid, rd_req, bad, sda_lo, drop;
  dac_host_pkg::dac_word_t     word, got;
  dac_host_pkg::readback_sel_t rb_sel;
  int                          err_count = 0, tests_run = 0, n_word = 0, n_bad = 0, n_rd = 0, n_drop = 0;
  logic [47:0]                 cap;
  logic [7:0]                  acks;
  wire                         sda = sda_m & (sda_oe ? sda_lo : 1'b1);
  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
  begin
    n_bad += int'(bad === 1'b1);
    n_rd += int'(rd_req === 1'b1);
    n_drop += int'(drop === 1'b1);
    n_word += int'(word_valid === 1'b1);
    if (word_valid === 1'b1)
      got = word;
  end
  dac_host_model u_dac_host_model (.clk_sys(clk_sys), .so(so), .sda(sda), .sclk(sclk), .sync_n(sync_n),
    .din(din), .scl(scl), .sda_m(sda_m));
  dac_serial_host_interface u_dac_serial_host_interface (.clk_sys(clk_sys), .rst(rst), .sclk_pin(sclk),
    .sync_n_pin(sync_n), .din_pin(din), .chain_enable_pin(chain), .serial_out_pin(so),
    .serial_parallel_select(1'b1), .serial_type_select(stype), .scl_pin(scl), .sda_in(sda), .sda_out(sda_lo),
    .sda_oe(sda_oe), .bus_addr_pin_hi(1'b1), .bus_addr_pin_lo(1'b0), .word_valid(word_valid),
    .word_ready(rdy), .word(word), .readback_req(rd_req), .readback_sel(rb_sel),
    .readback_data(rb_data), .bad_frame(bad), .word_dropped(drop));
  task automatic print_verdict;
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_frames;
    u_dac_host_model.frame(48'h0000_009f_9234, 24, cap);
    `CHK("word", {1'b1, 5'h1f, 2'b10, 14'h1234}, got)
    u_dac_host_model.frame(48'h0000_0000_03ff, 10, cap);
    `CHK("bad", 1, n_bad)
    `CHK("nopush", 1, n_word)
    rb_data <= 14'h2a5c;
    u_dac_host_model.frame(48'h0000_0042_7fff, 24, cap);
    `CHK("rdreq", 1, n_rd)
    `CHK("rdsel", 7'h09, rb_sel)
    u_dac_host_model.frame(48'h0000_0000_0000, 24, cap);
    `CHK("rback", {10'h109, 14'h2a5c}, cap[23:0])
  endtask
  task automatic t_chain;
    chain <= 1'b1;
    u_dac_host_model.frame(48'h8a5a_5a05_0001, 48, cap);
    `CHK("chain", 24'h8a_5a5a, cap[23:0])
    `CHK("keep", {1'b0, 5'h05, 2'b00, 14'h0001}, got)
    chain <= 1'b0;
  endtask
  task automatic t_two;
    stype <= 1'b1;
    repeat (4) @(posedge clk_sys);
    u_dac_host_model.xfer(64'hac03_8123, 4, acks);
    `CHK("ack", 8'h00, acks)
    `CHK("i2c", {1'b0, 5'h03, 2'b10, 14'h0123}, got)
    u_dac_host_model.xfer(64'h00ac_0381_2305_4011, 7, acks);
    `CHK("ack3", 8'h00, acks)
    `CHK("three", {1'b0, 5'h05, 2'b01, 14'h0011}, got)
    u_dac_host_model.xfer(64'hacff_4007_4008, 6, acks);
    `CHK("burst", {1'b0, 5'h01, 2'b01, 14'h0008}, got)
    u_dac_host_model.xfer(64'h00ad, 1, acks);
    `CHK("nack", 8'h01, acks)
  endtask
  task automatic t_full;
    stype <= 1'b0;
    rdy <= 1'b0;
    repeat (4) @(posedge clk_sys);
    repeat (34) u_dac_host_model.frame(48'h0000_0000_4001, 24, cap);
    `CHK("drop", 1, n_drop)
    rdy <= 1'b1;
    repeat (40) @(posedge clk_sys);
    `CHK("drained", 1'b0, word_valid)
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_frames();
    t_chain();
    t_two();
    t_full();
    print_verdict();
  end
  initial
  begin
    #3ms;
    err_count++;
    print_verdict();
  end
endmodule // test_dac_serial_host_interface
